//--- lcr_cell.sv
/*
 * Configurable logic cell: two 4-input tables, a combining table, carry
 * logic, two flops and an optional 16 x 2 / 32 x 1 memory mode.
 * Assumes fabric pins are asynchronous to clk_i and a classic Wishbone master.
 */
`timescale 1ns/1ns
`default_nettype none

module lcr_cell (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Wishbone slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [lcr_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   // Fabric inputs
   input  wire logic [3:0]               lut_a_inputs_i,
   input  wire logic [3:0]               lut_b_inputs_i,
   input  wire logic                     third_table_input_i,
   input  wire logic                     ram_data_input_i,
   input  wire logic                     ram_fifth_address_i,
   input  wire logic                     flop_gate_i,
   input  wire logic                     set_reset_i,
   input  wire logic                     cell_clock_i,
   input  wire logic                     carry_in_i,
   // Fabric outputs
   output logic                          comb_x_o,
   output logic                          comb_y_o,
   output logic                          first_flop_output_o,
   output logic                          second_flop_output_o,
   output logic                          carry_out_o
);
   import lcr_pkg::*;

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] pin_q;
   logic              ck_prev_q;
   wire  [SYNC_W-1:0] pin_raw;

   assign pin_raw = {carry_in_i, cell_clock_i, set_reset_i, flop_gate_i,
                     ram_fifth_address_i, ram_data_input_i,
                     third_table_input_i, lut_b_inputs_i, lut_a_inputs_i};

   // Two stages per pin; only pin_q is looked at by the cell logic
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q    <= '0;
         pin_q     <= '0;
         ck_prev_q <= 1'b0;
      end else begin
         meta_q    <= pin_raw;
         pin_q     <= meta_q;
         ck_prev_q <= pin_q[PIN_CK];
      end
   end

   wire [3:0] la   = pin_q[PIN_LA +: 4];
   wire [3:0] lb   = pin_q[PIN_LB +: 4];
   wire       h1   = pin_q[PIN_H1];
   wire       d0   = pin_q[PIN_D0];
   wire       d1   = pin_q[PIN_D1];
   wire       gate = pin_q[PIN_GATE];
   wire       sr   = pin_q[PIN_SR];
   wire       cin  = pin_q[PIN_CIN];

   // ************************************************************
   // Configuration registers
   // ************************************************************
   logic [7:0]  comb_q;
   logic [15:0] ctrl_q;

   wire carry_en = ctrl_q[CTL_CARRY];
   wire sub_en   = ctrl_q[CTL_SUB];
   wire ram_en   = ctrl_q[CTL_RAM];
   wire wide_en  = ctrl_q[CTL_WIDE];
   wire edge_x   = ctrl_q[CTL_EDGE_X];
   wire edge_y   = ctrl_q[CTL_EDGE_Y];
   wire out_x_h  = ctrl_q[CTL_OUT_X];
   wire out_y_h  = ctrl_q[CTL_OUT_Y];
   wire lcr_src_t src_x = lcr_src_t'(ctrl_q[CTL_SRC_X +: 2]);
   wire lcr_src_t src_y = lcr_src_t'(ctrl_q[CTL_SRC_Y +: 2]);
   wire lcr_sr_t  sr_x  = lcr_sr_t'(ctrl_q[CTL_SR_X +: 2]);
   wire lcr_sr_t  sr_y  = lcr_sr_t'(ctrl_q[CTL_SR_Y +: 2]);

   // ************************************************************
   // Cell clock edges
   // ************************************************************
   // The cell clock is sampled, so it must stay well below clk_i / 4
   wire ck_rise = pin_q[PIN_CK] & ~ck_prev_q;
   wire ck_fall = ~pin_q[PIN_CK] & ck_prev_q;
   wire act_x   = edge_x ? ck_fall : ck_rise;
   wire act_y   = edge_y ? ck_fall : ck_rise;

   // ************************************************************
   // Memory mode write decode
   // ************************************************************
   // The strobe shares the set/reset pin; the first flop's edge times writes
   wire ram_we   = ram_en & sr & act_x;
   wire we_a     = ram_we & (~wide_en | ~d1);
   wire we_b     = ram_we & (~wide_en | d1);
   wire wdat_a   = wide_en ? d0 : h1;
   wire wdat_b   = d0;

   // ************************************************************
   // Software access decode
   // ************************************************************
   logic        ack_q;
   wire         req     = wb_cyc_i & wb_stb_i;
   wire         wr_fire = req & wb_we_i & ack_q;
   wire         hit_a   = wb_adr_i == ADR_LUT_A;
   wire         hit_b   = wb_adr_i == ADR_LUT_B;
   wire         hit_c   = wb_adr_i == ADR_COMB;
   wire         hit_k   = wb_adr_i == ADR_CTRL;
   wire         hit_s   = wb_adr_i == ADR_STAT;
   wire [15:0]  tab_a;
   wire [15:0]  tab_b;
   wire [31:0]  new_a;
   wire [31:0]  new_b;
   wire [31:0]  new_c;
   wire [31:0]  new_k;

   // Byte lanes not selected keep their old value
   function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return m;
   endfunction : merge_lanes

   assign new_a = merge_lanes({16'h0000, tab_a}, wb_dat_i, wb_sel_i);
   assign new_b = merge_lanes({16'h0000, tab_b}, wb_dat_i, wb_sel_i);
   assign new_c = merge_lanes({24'h000000, comb_q}, wb_dat_i, wb_sel_i);
   assign new_k = merge_lanes({16'h0000, ctrl_q}, wb_dat_i, wb_sel_i);

   // ************************************************************
   // Look-up tables
   // ************************************************************
   wire lut_f;
   wire lut_g;

   lcr_lut u_lut_a (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .cfg_we_i  (wr_fire & hit_a),
      .cfg_dat_i (new_a[15:0]),
      .ram_we_i  (we_a),
      .addr_i    (la),
      .ram_dat_i (wdat_a),
      .rd_o      (lut_f),
      .table_o   (tab_a)
   );

   lcr_lut u_lut_b (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .cfg_we_i  (wr_fire & hit_b),
      .cfg_dat_i (new_b[15:0]),
      .ram_we_i  (we_b),
      .addr_i    (lb),
      .ram_dat_i (wdat_b),
      .rd_o      (lut_g),
      .table_o   (tab_b)
   );

   // ************************************************************
   // Carry logic
   // ************************************************************
   // Operand bits: table A inputs 0/1 are a0/b0, table B inputs 0/1 are a1/b1.
   // A counter feeds its flops back as a; up counts with b=0, cin=1,
   // down with subtract, b=0, cin=0; a load goes through the direct input.
   wire carry_on = carry_en & ~ram_en;
   wire b1       = lb[1] ^ sub_en;
   wire bb0      = la[1] ^ sub_en;
   wire s0       = la[0] ^ bb0 ^ cin;
   wire c1       = (la[0] & bb0) | (cin & (la[0] ^ bb0));
   wire s1       = lb[0] ^ b1 ^ c1;
   wire c2       = (lb[0] & b1) | (c1 & (lb[0] ^ b1));
   wire f_out    = carry_on ? s0 : lut_f;
   wire g_out    = carry_on ? s1 : lut_g;
   wire cout     = carry_on & c2;

   // ************************************************************
   // Combining table and output selection
   // ************************************************************
   wire       h_in3 = ram_en ? d1 : h1;
   wire [2:0] h_idx = {h_in3, g_out, f_out};
   wire       h_out = comb_q[h_idx];
   wire       x_d   = out_x_h ? h_out : f_out;
   wire       y_d   = out_y_h ? h_out : g_out;

   // Flop data sources, independent of what X and Y show
   wire din_x = (src_x == LCR_SRC_F) ? f_out :
                (src_x == LCR_SRC_G) ? g_out :
                (src_x == LCR_SRC_H) ? h_out : d0;
   wire din_y = (src_y == LCR_SRC_F) ? f_out :
                (src_y == LCR_SRC_G) ? g_out :
                (src_y == LCR_SRC_H) ? h_out : d0;

   // Set/reset acts at once, ignoring clock and gate; memory mode owns the pin
   wire sr_hit_x = sr & ~ram_en & (sr_x == LCR_SR_SET || sr_x == LCR_SR_RST);
   wire sr_hit_y = sr & ~ram_en & (sr_y == LCR_SR_SET || sr_y == LCR_SR_RST);
   wire take_x   = act_x & gate;
   wire take_y   = act_y & gate;

   // ************************************************************
   // Cell flops
   // ************************************************************
   logic fq_x_q;
   logic fq_y_q;

   // First flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fq_x_q <= 1'b0;
      end else if (sr_hit_x) begin
         fq_x_q <= (sr_x == LCR_SR_SET);
      end else if (take_x) begin
         fq_x_q <= din_x;
      end
   end

   // Second flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fq_y_q <= 1'b0;
      end else if (sr_hit_y) begin
         fq_y_q <= (sr_y == LCR_SR_SET);
      end else if (take_y) begin
         fq_y_q <= din_y;
      end
   end

   // ************************************************************
   // Output stage
   // ************************************************************
   // Every output is registered, so X, Y and carry lag the synchronised pins by a cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comb_x_o             <= 1'b0;
         comb_y_o             <= 1'b0;
         carry_out_o          <= 1'b0;
         first_flop_output_o  <= 1'b0;
         second_flop_output_o <= 1'b0;
      end else begin
         comb_x_o             <= x_d;
         comb_y_o             <= y_d;
         carry_out_o          <= cout;
         first_flop_output_o  <= fq_x_q;
         second_flop_output_o <= fq_y_q;
      end
   end

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   wire [31:0] stat_w = {26'h0, carry_out_o, h_out, g_out, f_out,
                         fq_y_q, fq_x_q};
   wire [31:0] rd_mux = hit_a ? {16'h0000, tab_a} :
                        hit_b ? {16'h0000, tab_b} :
                        hit_c ? {24'h000000, comb_q} :
                        hit_k ? {16'h0000, ctrl_q} :
                        hit_s ? stat_w : 32'h00000000;

   // One wait state: ack in the cycle after the request, dropped after one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q    <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         ack_q    <= req & ~ack_q;
         if (req & ~ack_q & ~wb_we_i) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

   assign wb_ack_o = ack_q;

   // Writes land on the edge where the master sees ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comb_q <= COMB_RST;
         ctrl_q <= CTRL_RST;
      end else begin
         if (wr_fire & hit_c) begin
            comb_q <= new_c[7:0];
         end
         if (wr_fire & hit_k) begin
            ctrl_q <= new_k[15:0];
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cell_cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   wire [2:0] add_ref = {2'b00, la[0]} + {2'b00, bb0} + {2'b00, cin}
                        + {1'b0, lb[0], 1'b0} + {1'b0, b1, 1'b0};

   sequence wb_take_s;
      req && !ack_q;
   endsequence

   sequence wb_done_s;
      ack_q ##1 !ack_q;
   endsequence

   bus_ack_pulse_a : assert property (wb_take_s |=> wb_done_s)
      else $error("ack not a single cycle after request");

   carry_sum_a : assert property (
      carry_on |=> carry_out_o == $past(add_ref[2])
                   && comb_y_o == ($past(out_y_h) ? comb_y_o : $past(add_ref[1])))
      else $error("carry sum mismatch");

   carry_off_a : assert property (!carry_on |=> !carry_out_o)
      else $error("carry out while carry disabled");

   flop_capture_a : assert property (
      take_x && !sr_hit_x && src_x == LCR_SRC_DIN |=> ##1 first_flop_output_o == $past(d0, 2))
      else $error("first flop missed the direct input");

   flop_hold_a : assert property (
      !take_y && !sr_hit_y |=> fq_y_q == $past(fq_y_q))
      else $error("second flop moved without its edge");

   // A falling-edge flop must ignore the rising cell clock edge
   edge_select_a : assert property (
      edge_y && !ck_fall && !sr_hit_y |=> fq_y_q == $past(fq_y_q))
      else $error("falling-edge flop moved on a rising edge");

   set_reset_a : assert property (
      sr_hit_x |=> ##1 first_flop_output_o == ($past(sr_x, 2) == LCR_SR_SET))
      else $error("set/reset did not force the first flop");

   ram_strobe_a : assert property (
      ram_en && sr && act_x && !wide_en |-> we_a && we_b)
      else $error("16x2 write did not reach both tables");

   ram_wide_sel_a : assert property (
      ram_we && wide_en |-> (we_a != we_b) && (we_b == d1))
      else $error("32x1 write hit the wrong table");

   ram_read_out_a : assert property (
      ram_en && !out_x_h |=> comb_x_o == $past(lut_f))
      else $error("memory read not on X output");

   comb_ram_a : assert property (
      ram_en |-> h_out == comb_q[{d1, g_out, f_out}])
      else $error("combining table not fed by fifth address");

endmodule : lcr_cell

`default_nettype wire

//--- lcr_fab_model.sv
/* Fabric-side partner: drives the cell pins as the surrounding user logic would.
   Assumes the bench clock; pins change only just after its rising edge. */
`timescale 1ns/1ns
`default_nettype none

module lcr_fab_model (
   // Clock
   input  wire logic                  clk_i,
   // Cell pins, packed at the synchroniser positions
   output logic [lcr_pkg::SYNC_W-1:0] pin_o
);
   import lcr_pkg::*;

   initial pin_o = '0;

   // Hold five cycles: two sync stages, the edge detect and the output flops
   task automatic drive(input logic [SYNC_W-1:0] nv);
      @(posedge clk_i);
      pin_o <= nv;
      repeat (5) @(posedge clk_i);
   endtask : drive

   // Six-cycle cell clock pulse, so data and strobe stay put around both edges
   task automatic pulse();
      drive(pin_o | 15'h2000);
      drive(pin_o & 15'h5FFF);
   endtask : pulse
endmodule : lcr_fab_model

`default_nettype wire

//--- lcr_lut.sv
/*
 * One 16-entry look-up table that doubles as a 16 x 1 write port memory.
 * Assumes both write requests come from the same clock domain; software wins.
 */
`timescale 1ns/1ns
`default_nettype none

module lcr_lut (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Whole-table load from software
   input  wire logic        cfg_we_i,
   input  wire logic [15:0] cfg_dat_i,
   // Single-entry write and read
   input  wire logic        ram_we_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic        ram_dat_i,
   // Results
   output logic             rd_o,
   output logic [15:0]      table_o
);
   import lcr_pkg::*;

   logic [15:0] mem_q;

   // Table contents; a software load overrides a fabric write in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_q <= LUT_RST;
      end else if (cfg_we_i) begin
         mem_q <= cfg_dat_i;
      end else if (ram_we_i) begin
         mem_q[addr_i] <= ram_dat_i;
      end
   end

   // Read is purely combinational from the address
   assign rd_o    = mem_q[addr_i];
   assign table_o = mem_q;

   default clocking lut_cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ram_write_lands_a : assert property (
      ram_we_i && !cfg_we_i |=> mem_q[$past(addr_i)] == $past(ram_dat_i))
      else $error("memory write did not land");

   cfg_load_a : assert property (
      cfg_we_i |=> table_o == $past(cfg_dat_i))
      else $error("table load did not land");

endmodule : lcr_lut

`default_nettype wire

//--- lcr_pkg.sv
/*
 * Constants, field positions and encodings shared by the logic cell files.
 * Assumes a 32-bit classic Wishbone bus with byte addresses on wb_adr_i.
 */
`default_nettype none

package lcr_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam int unsigned ADR_W      = 8;
   localparam logic [7:0]  ADR_LUT_A  = 8'h00;
   localparam logic [7:0]  ADR_LUT_B  = 8'h04;
   localparam logic [7:0]  ADR_COMB   = 8'h08;
   localparam logic [7:0]  ADR_CTRL   = 8'h0C;
   localparam logic [7:0]  ADR_STAT   = 8'h10;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] LUT_RST    = 16'h0000;
   localparam logic [7:0]  COMB_RST   = 8'h00;
   localparam logic [15:0] CTRL_RST   = 16'h0000;

   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int CTL_CARRY  = 0;
   localparam int CTL_SUB    = 1;
   localparam int CTL_RAM    = 2;
   localparam int CTL_WIDE   = 3;
   localparam int CTL_SRC_X  = 4;
   localparam int CTL_SRC_Y  = 6;
   localparam int CTL_SR_X   = 8;
   localparam int CTL_SR_Y   = 10;
   localparam int CTL_EDGE_X = 12;
   localparam int CTL_EDGE_Y = 13;
   localparam int CTL_OUT_X  = 14;
   localparam int CTL_OUT_Y  = 15;

   // ************************************************************
   // Positions of the fabric pins inside the synchroniser vector
   // ************************************************************
   localparam int SYNC_W   = 15;
   localparam int PIN_LA   = 0;
   localparam int PIN_LB   = 4;
   localparam int PIN_H1   = 8;
   localparam int PIN_D0   = 9;
   localparam int PIN_D1   = 10;
   localparam int PIN_GATE = 11;
   localparam int PIN_SR   = 12;
   localparam int PIN_CK   = 13;
   localparam int PIN_CIN  = 14;

   // ************************************************************
   // Encodings
   // ************************************************************
   typedef enum logic [1:0] {
      LCR_SRC_F   = 2'h0,
      LCR_SRC_G   = 2'h1,
      LCR_SRC_H   = 2'h2,
      LCR_SRC_DIN = 2'h3
   } lcr_src_t;

   typedef enum logic [1:0] {
      LCR_SR_OFF = 2'h0,
      LCR_SR_SET = 2'h1,
      LCR_SR_RST = 2'h2,
      LCR_SR_NA  = 2'h3
   } lcr_sr_t;

endpackage : lcr_pkg

`default_nettype wire

//--- tb_top.sv
/* Self-checking bench: bus reads and cell pins are compared with queued notes.
   Assumes the fabric model drives every cell pin. */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   import lcr_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack, cx, cy, q1o, q2o, co, pin_stb, q1, q2;
   logic [7:0]  adr, cm;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [14:0] v;
   logic [15:0] la, lb, ctl;
   int          n_errors, checks_done;
   logic [31:0] exp_q[$];
   logic [4:0]  pin_q[$];
   wire  [14:0] pin;

   // Free-running 125 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   lcr_fab_model lcr_fab_model_inst (.clk_i(clk_i), .pin_o(pin));
   lcr_cell lcr_cell_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .lut_a_inputs_i(pin[3:0]), .lut_b_inputs_i(pin[7:4]), .third_table_input_i(pin[8]),
      .ram_data_input_i(pin[9]), .ram_fifth_address_i(pin[10]), .flop_gate_i(pin[11]),
      .set_reset_i(pin[12]), .cell_clock_i(pin[13]), .carry_in_i(pin[14]), .comb_x_o(cx),
      .comb_y_o(cy), .first_flop_output_o(q1o), .second_flop_output_o(q2o), .carry_out_o(co));

   // ****
   // Checking
   // ****
   task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp_word

   task automatic cmp_pins(input logic [4:0] e, input logic [4:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp_pins

   // Oldest note is taken whenever a read is acknowledged or a pin sample is due
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0)
         cmp_word(exp_q.pop_front(), rdat);
      if (pin_stb)
         cmp_pins(pin_q.pop_front(), {co, q2o, q1o, cy, cx});
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   // Hang guard, far above the roughly 740 cycles the tests take
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      stop_test();
   end

   // ****
   // Bus and pin helpers
   // ****
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      {cyc, stb} <= 2'b00;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask : rd

   task automatic chk(input logic [4:0] e);
      pin_q.push_back(e);
      pin_stb <= 1'b1;
      @(posedge clk_i);
      pin_stb <= 1'b0;
   endtask : chk

   // Expected {H, G, F} from the tables and the pins now driven
   function automatic logic [2:0] fgh();
      logic f, g;
      f = la[v[3:0]];
      g = lb[v[7:4]];
      return {cm[{ctl[CTL_RAM] ? v[PIN_D1] : v[PIN_H1], g, f}], g, f};
   endfunction : fgh

   function automatic logic src(input int c);
      logic [2:0] r;
      r = fgh();
      return (c == 3) ? v[PIN_D0] : r[c];
   endfunction : src

   task automatic expect_all();
      logic [2:0] r;
      r = fgh();
      chk({1'b0, q2, q1, ctl[CTL_OUT_Y] ? r[2] : r[1], ctl[CTL_OUT_X] ? r[2] : r[0]});
      rd(ADR_STAT, {27'h0, r, q2, q1});
   endtask : expect_all

   // ****
   // Tests
   // ****
   initial begin
      int i;
      logic [2:0] s;
      {cyc, stb, we, pin_stb, rst_i} = 5'b00001;
      {adr, sel, wdat, la, lb, cm, ctl, v, q1, q2} = '0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      void'($urandom(32'h3F1A));
      for (i = 0; i < 5; i++)
         rd(8'(4 * i), 32'h0);
      wb(1'b1, 8'h20, 32'hFFFF_FFFF);
      wb(1'b1, ADR_STAT, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0);
      rd(ADR_STAT, 32'h0);
      $display("test reset and map done");
      for (i = 0; i < 4; i++) begin
         {la, lb, cm} = {16'($urandom), 16'($urandom), 8'($urandom)};
         ctl = 16'(i) << CTL_SRC_X | 16'(3 - i) << CTL_SRC_Y | 16'(i) << CTL_OUT_X | 16'h0001 << CTL_EDGE_Y;
         wb(1'b1, ADR_LUT_A, {16'h0, la});
         wb(1'b1, ADR_LUT_B, {16'h0, lb});
         wb(1'b1, ADR_COMB, {24'h0, cm});
         wb(1'b1, ADR_CTRL, {16'h0, ctl});
         v = {4'h1, 11'($urandom)};
         lcr_fab_model_inst.drive(v);
         // Rising edge only: the falling-edge second flop must still hold
         v[PIN_CK] = 1'b1;
         lcr_fab_model_inst.drive(v);
         q1 = src(i);
         expect_all();
         v[PIN_CK] = 1'b0;
         lcr_fab_model_inst.drive(v);
         q2 = src(3 - i);
         expect_all();
         v[PIN_GATE] = 1'b0;
         v[PIN_D0] = ~v[PIN_D0];
         lcr_fab_model_inst.drive(v);
         lcr_fab_model_inst.pulse();
         expect_all();
      end
      for (i = 1; i < 3; i++) begin
         ctl = 16'(i) << CTL_SR_X | 16'(3 - i) << CTL_SR_Y;
         wb(1'b1, ADR_CTRL, {16'h0, ctl});
         v[PIN_SR] = 1'b1;
         lcr_fab_model_inst.drive(v);
         {q1, q2} = {i == 1, i == 2};
         expect_all();
         v[PIN_SR] = 1'b0;
         lcr_fab_model_inst.drive(v);
      end
      $display("test logic and flops done");
      for (i = 0; i < 4; i++) begin
         ctl = {14'h0, i[0], 1'b1};
         wb(1'b1, ADR_CTRL, {16'h0, ctl});
         v = {1'($urandom), 3'h0, 11'($urandom)};
         s = {1'b0, v[4], v[0]} + {1'b0, v[5] ^ ctl[1], v[1] ^ ctl[1]} + {2'b0, v[PIN_CIN]};
         lcr_fab_model_inst.drive(v);
         chk({s[2], q2, q1, s[1], s[0]});
      end
      $display("test carry done");
      for (i = 0; i < 8; i++) begin
         ctl = 16'h0044 | 16'(i / 4) << CTL_WIDE;
         wb(1'b1, ADR_CTRL, {16'h0, ctl});
         v = {4'h0, 11'($urandom)};
         v[7:4] = v[3:0];
         v[PIN_SR] = (i % 4 != 1);
         lcr_fab_model_inst.drive(v);
         lcr_fab_model_inst.pulse();
         if (v[PIN_SR] && (!ctl[CTL_WIDE] || !v[PIN_D1]))
            la[v[3:0]] = ctl[CTL_WIDE] ? v[PIN_D0] : v[PIN_H1];
         if (v[PIN_SR] && (!ctl[CTL_WIDE] || v[PIN_D1]))
            lb[v[3:0]] = v[PIN_D0];
         expect_all();
         {v[PIN_SR], v[PIN_GATE]} = 2'b01;
         lcr_fab_model_inst.drive(v);
         lcr_fab_model_inst.pulse();
         {q1, q2} = {src(0), src(1)};
         expect_all();
      end
      $display("test memory done");
      stop_test();
   end
endmodule : tb_top

`default_nettype wire
